/* pkg/otc_pkg.sv */
/*
  Constants for the internal oscillator trim and multiplier control.
  Assumes a 40 MHz control clock and a single tuning register.
*/
package otc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int OTC_ADDR_W = 4;
  localparam logic [3:0] OTC_TRIM_ADDR = 4'h0;
  localparam logic [7:0] OTC_TRIM_RESET = 8'h00;
  localparam int OTC_LFSRC_BIT = 7;
  localparam int OTC_MULT_BIT = 6;
  localparam int OTC_TRIM_MSB = 4;
  localparam int OTC_TRIM_W = 5;
  localparam logic [4:0] OTC_TRIM_CENTRE = 5'h00;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OTC_PCFG_INT_A = 4'h9;
  localparam logic [3:0] OTC_PCFG_INT_B = 4'h8;
  localparam logic [2:0] OTC_IFS_8M = 3'h7;
  localparam logic [2:0] OTC_IFS_4M = 3'h6;
  localparam logic [2:0] OTC_IFS_2M = 3'h5;
  localparam logic [2:0] OTC_IFS_1M = 3'h4;
  localparam logic [2:0] OTC_IFS_500K = 3'h3;
  localparam logic [2:0] OTC_IFS_250K = 3'h2;
  localparam logic [2:0] OTC_IFS_125K = 3'h1;
  localparam logic [2:0] OTC_IFS_31K = 3'h0;

  // ----------------------------------------------------------------
  // Nominal frequencies in kHz
  // ----------------------------------------------------------------
  localparam logic [15:0] OTC_F8M_KHZ = 16'h1f40;
  localparam logic [15:0] OTC_F4M_KHZ = 16'h0fa0;
  localparam logic [15:0] OTC_F2M_KHZ = 16'h07d0;
  localparam logic [15:0] OTC_F1M_KHZ = 16'h03e8;
  localparam logic [15:0] OTC_F500K_KHZ = 16'h01f4;
  localparam logic [15:0] OTC_F250K_KHZ = 16'h00fa;
  localparam logic [15:0] OTC_F125K_KHZ = 16'h007d;
  localparam logic [15:0] OTC_F31K_KHZ = 16'h001f;
  localparam int OTC_MULT_SHIFT = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OTC_CLK_MHZ = 40;
  localparam int OTC_SETTLE_US = 1000;
  localparam int OTC_SETTLE_CYCLES = OTC_SETTLE_US * OTC_CLK_MHZ;
  localparam int OTC_TRIM_STEPS = 32;
  localparam int OTC_LF_DIV = 256;
  localparam logic [7:0] OTC_LF_DIV_LAST = 8'(OTC_LF_DIV - 1);

  // Slew unit states, Gray along idle -> slewing
  typedef enum logic [1:0] {
    OTC_SLEW_IDLE = 2'h0,
    OTC_SLEW_MOVE = 2'h1
  } otc_slew_e;

endpackage : otc_pkg

/* rtl/otc_osc_ctrl.sv */
/*
  Internal oscillator control: tuning register, trim slewing,
  low-frequency source select and the 4x multiplier gate.
  Assumes oscillator ticks and config inputs are synchronous to mclk.
*/
`timescale 1ns/1ps

// Function
// - Centre trim gives calibrated 8 MHz
// - RC oscillator ignores trim register
// - Five-bit trim field tunes main oscillator
// - Trim settles within 1 ms, no flag
// - 01111 max, 00000 centre, 10000 min
// - Bit 7 picks divide-by-256 or RC
// - Multiplier gives four times selected clock
// - Bit 6 enables multiplier, software only
// - Multiplier needs internal config and 8/4 MHz
// - Unused bits read zero, ignore writes
// - Select 111 is 8 MHz, 110 4 MHz
// - RC at 31 kHz stops main oscillator
module otc_osc_ctrl #(
  parameter int SETTLE_CYCLES = otc_pkg::OTC_SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,

  // Register port
  input wire logic [otc_pkg::OTC_ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,

  // Clock configuration from outside
  input wire logic [3:0] primary_clock_config,
  input wire logic [2:0] internal_freq_select,

  // Oscillator ticks
  input wire logic main_osc_tick,
  input wire logic rc_osc_tick,

  // Oscillator controls
  output logic [otc_pkg::OTC_TRIM_W-1:0] osc_trim_code,
  output logic main_osc_enable,
  output logic freq_multiplier_active,

  // Low-frequency clock
  output logic low_freq_source_select,
  output logic low_freq_tick,

  // Nominal frequencies
  output logic [15:0] base_freq_khz,
  output logic [15:0] device_freq_khz
);
  import otc_pkg::*;

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------

  // Longest time rounds down so a full walk ends inside the window
  localparam int STEP_CYCLES = SETTLE_CYCLES / OTC_TRIM_STEPS;

  generate
    if (SETTLE_CYCLES < OTC_TRIM_STEPS) begin : g_bad_settle_lo
      $error("otc_osc_ctrl: SETTLE_CYCLES too small");
    end
    if (STEP_CYCLES > 65535) begin : g_bad_settle_hi
      $error("otc_osc_ctrl: SETTLE_CYCLES too large");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------

  logic [OTC_TRIM_W-1:0] trim_reg;
  logic lfsrc_reg;
  logic mult_en_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] read_word;
  logic trim_hit;
  logic trim_wr;
  logic trim_rd;

  // Decode of the single mapped word
  assign trim_hit = (addr == OTC_TRIM_ADDR);
  assign trim_wr = wr_stb && trim_hit;
  assign trim_rd = rd_stb && trim_hit;

  // ----------------------------------------------------------------
  // Multiplier qualification
  // ----------------------------------------------------------------

  logic cfg_internal;
  logic ifs_fast;
  logic mult_qual;

  // Multiplier is legal only in internal primary mode at 8 or 4 MHz
  assign cfg_internal = (primary_clock_config == OTC_PCFG_INT_A)
                     || (primary_clock_config == OTC_PCFG_INT_B);
  assign ifs_fast = (internal_freq_select == OTC_IFS_8M)
                 || (internal_freq_select == OTC_IFS_4M);
  assign mult_qual = cfg_internal && ifs_fast;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Trim field; the whole five bits take the written value
  always_ff @(posedge mclk) begin
    if (srst) begin
      trim_reg <= OTC_TRIM_RESET[OTC_TRIM_MSB:0];
    end else if (trim_wr) begin
      trim_reg <= wr_data[OTC_TRIM_MSB:0];
    end
  end

  // Low-frequency source select bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      lfsrc_reg <= OTC_TRIM_RESET[OTC_LFSRC_BIT];
    end else if (trim_wr) begin
      lfsrc_reg <= wr_data[OTC_LFSRC_BIT];
    end
  end

  // Multiplier enable; dropped the moment qualification is lost,
  // and a write while unqualified cannot set it
  always_ff @(posedge mclk) begin
    if (srst) begin
      mult_en_reg <= OTC_TRIM_RESET[OTC_MULT_BIT];
    end else if (!mult_qual) begin
      mult_en_reg <= 1'b0;
    end else if (trim_wr) begin
      mult_en_reg <= wr_data[OTC_MULT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Bit 5 is hard zero; nothing stores it
  always_comb begin
    read_word = 8'h00;
    read_word[OTC_LFSRC_BIT] = lfsrc_reg;
    read_word[OTC_MULT_BIT] = mult_en_reg;
    read_word[OTC_TRIM_MSB:0] = trim_reg;
  end

  // Read data valid only in the cycle after the strobe;
  // unmapped addresses answer zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data_reg <= 8'h00;
    end else if (trim_rd) begin
      rd_data_reg <= read_word;
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  assign rd_data = rd_data_reg;

  // ----------------------------------------------------------------
  // Trim slewing
  // ----------------------------------------------------------------

  // The applied code walks in steps so the oscillator never jumps;
  // there is deliberately no done flag for software to poll
  otc_trim_slew #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_slew (
    .mclk(mclk),
    .srst(srst),
    .target(trim_reg),
    .trim_code(osc_trim_code)
  );

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------

  logic main_en_reg;
  logic mult_act_reg;
  logic lf_rc_only;

  // Only 31 kHz from the RC source lets the main oscillator sleep
  assign lf_rc_only = (internal_freq_select == OTC_IFS_31K)
                   && !lfsrc_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      main_en_reg <= 1'b0;
    end else begin
      main_en_reg <= !lf_rc_only;
    end
  end

  // Multiplier runs only with the bit set and still qualified
  always_ff @(posedge mclk) begin
    if (srst) begin
      mult_act_reg <= 1'b0;
    end else begin
      mult_act_reg <= mult_en_reg && mult_qual;
    end
  end

  assign main_osc_enable = main_en_reg;
  assign freq_multiplier_active = mult_act_reg;

  // ----------------------------------------------------------------
  // Low-frequency clock
  // ----------------------------------------------------------------

  logic [7:0] div_cnt_reg;
  logic lf_tick_reg;
  logic lfsrc_out_reg;
  logic div_wrap;

  // Divider free-runs on main ticks so a switch to it is immediate
  assign div_wrap = main_osc_tick && (div_cnt_reg == OTC_LF_DIV_LAST);

  always_ff @(posedge mclk) begin
    if (srst) begin
      div_cnt_reg <= 8'h00;
    end else if (main_osc_tick) begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // RC path takes the tick untouched; trim never reaches it
  always_ff @(posedge mclk) begin
    if (srst) begin
      lf_tick_reg <= 1'b0;
    end else if (lfsrc_reg) begin
      lf_tick_reg <= div_wrap;
    end else begin
      lf_tick_reg <= rc_osc_tick;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lfsrc_out_reg <= 1'b0;
    end else begin
      lfsrc_out_reg <= lfsrc_reg;
    end
  end

  assign low_freq_tick = lf_tick_reg;
  assign low_freq_source_select = lfsrc_out_reg;

  // ----------------------------------------------------------------
  // Nominal frequency report
  // ----------------------------------------------------------------

  logic [15:0] base_khz;
  logic [15:0] base_reg;
  logic [15:0] dev_reg;

  // Nominal figures assume centre trim; trim offsets are not modelled
  always_comb begin
    unique case (internal_freq_select)
      OTC_IFS_8M: base_khz = OTC_F8M_KHZ;
      OTC_IFS_4M: base_khz = OTC_F4M_KHZ;
      OTC_IFS_2M: base_khz = OTC_F2M_KHZ;
      OTC_IFS_1M: base_khz = OTC_F1M_KHZ;
      OTC_IFS_500K: base_khz = OTC_F500K_KHZ;
      OTC_IFS_250K: base_khz = OTC_F250K_KHZ;
      OTC_IFS_125K: base_khz = OTC_F125K_KHZ;
      OTC_IFS_31K: base_khz = OTC_F31K_KHZ;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      base_reg <= 16'h0000;
    end else begin
      base_reg <= base_khz;
    end
  end

  // Four times the base when the multiplier is live
  always_ff @(posedge mclk) begin
    if (srst) begin
      dev_reg <= 16'h0000;
    end else if (mult_en_reg && mult_qual) begin
      dev_reg <= base_khz << OTC_MULT_SHIFT;
    end else begin
      dev_reg <= base_khz;
    end
  end

  assign base_freq_khz = base_reg;
  assign device_freq_khz = dev_reg;

endmodule : otc_osc_ctrl

/* rtl/otc_trim_slew.sv */
/*
  Trim slew unit: walks the applied trim code one signed step at a time
  toward the software target. Assumes target is a stable register.
*/
`timescale 1ns/1ps
module otc_trim_slew #(
  parameter int STEP_CYCLES = 1250
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Target from the register
  input wire logic [otc_pkg::OTC_TRIM_W-1:0] target,
  // Code applied to the oscillator
  output logic [otc_pkg::OTC_TRIM_W-1:0] trim_code
);
  import otc_pkg::*;

  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  generate
    if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_bad_step
      $error("otc_trim_slew: STEP_CYCLES out of range");
    end
  endgenerate

  otc_slew_e state_reg;
  logic [15:0] step_cnt_reg;
  logic [OTC_TRIM_W-1:0] code_reg;
  logic signed [OTC_TRIM_W-1:0] tgt_s;
  logic signed [OTC_TRIM_W-1:0] cur_s;

  assign tgt_s = signed'(target);
  assign cur_s = signed'(code_reg);
  assign trim_code = code_reg;

  // Step timer and walk; a new target mid-walk just redirects it
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= OTC_SLEW_IDLE;
      step_cnt_reg <= 16'h0000;
      code_reg <= OTC_TRIM_CENTRE;
    end else begin
      unique case (state_reg)
        OTC_SLEW_IDLE: begin
          step_cnt_reg <= 16'h0000;
          if (cur_s != tgt_s) begin
            state_reg <= OTC_SLEW_MOVE;
          end
        end
        OTC_SLEW_MOVE: begin
          if (cur_s == tgt_s) begin
            state_reg <= OTC_SLEW_IDLE;
          end else if (step_cnt_reg == STEP_LAST) begin
            step_cnt_reg <= 16'h0000;
            // Signed order keeps each step monotonic
            if (cur_s < tgt_s) begin
              code_reg <= code_reg + 5'h01;
            end else begin
              code_reg <= code_reg - 5'h01;
            end
          end else begin
            step_cnt_reg <= step_cnt_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= OTC_SLEW_IDLE;
        end
      endcase
    end
  end

endmodule : otc_trim_slew

/* testbench/otc_osc_ctrl_chk.sv */
/* Port checker for the oscillator trim control.
   Assumes one mclk domain and srst synchronous reset. */
`timescale 1ns/1ps
module otc_osc_ctrl_chk (
  // Clock, reset, register port
  input wire logic mclk,
  input wire logic srst,
  input wire logic [otc_pkg::OTC_ADDR_W-1:0] addr,
  input wire logic rd_stb,
  input wire logic [7:0] rd_data,
  // Configuration and ticks
  input wire logic [3:0] primary_clock_config,
  input wire logic [2:0] internal_freq_select,
  input wire logic rc_osc_tick,
  // Outputs watched
  input wire logic [otc_pkg::OTC_TRIM_W-1:0] osc_trim_code,
  input wire logic main_osc_enable,
  input wire logic freq_multiplier_active,
  input wire logic low_freq_source_select,
  input wire logic low_freq_tick,
  input wire logic [15:0] base_freq_khz,
  input wire logic [15:0] device_freq_khz
);
  import otc_pkg::*;
  logic qual;
  // Multiplier allowed only for internal config at 8 or 4 MHz
  assign qual = primary_clock_config inside {4'h9, 4'h8} &&
    internal_freq_select inside {3'h7, 3'h6};
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_unused_zero: assert property (rd_data[5] == 1'b0)
    else $error("unused bit read as one");
  a_read_lag: assert property (rd_data != 8'h00 |->
    $past(rd_stb) && $past(addr) == 4'h0) else $error("stray read data");
  a_mult_qual: assert property (freq_multiplier_active |-> $past(qual))
    else $error("multiplier on without qualification");
  a_mult_bit: assert property (rd_data[6] |-> $past(qual, 2))
    else $error("enable bit read while unqualified");
  a_mult_freq: assert property (freq_multiplier_active &&
    $past(freq_multiplier_active) && $stable(base_freq_khz) |->
    device_freq_khz == {base_freq_khz[13:0], 2'b00})
    else $error("device frequency not four times base");
  a_trim_step: assert property ($changed(osc_trim_code) |->
    5'(osc_trim_code - $past(osc_trim_code)) inside {5'h01, 5'h1f})
    else $error("trim code jumped");
  a_trim_hold: assert property ($changed(osc_trim_code) |=>
    $stable(osc_trim_code)) else $error("trim steps too close");
  a_osc_off: assert property (!main_osc_enable && !$past(srst) |->
    $past(internal_freq_select) == 3'h0) else $error("main osc off");
  a_rc_path: assert property (!low_freq_source_select &&
    !$past(low_freq_source_select) && !$past(srst) |->
    low_freq_tick == $past(rc_osc_tick)) else $error("rc tick not passed");
  c_mult: cover property (freq_multiplier_active);
  c_div: cover property (low_freq_source_select && low_freq_tick);
  c_trim: cover property ($changed(osc_trim_code));
endmodule : otc_osc_ctrl_chk

bind otc_osc_ctrl otc_osc_ctrl_chk i_chk (.mclk, .srst, .addr, .rd_stb,
  .rd_data, .primary_clock_config, .internal_freq_select, .rc_osc_tick,
  .osc_trim_code, .main_osc_enable, .freq_multiplier_active,
  .low_freq_source_select, .low_freq_tick, .base_freq_khz,
  .device_freq_khz);

/* testbench/testbench.sv */
/* Self-checking bench for the oscillator trim control.
   Assumes the checker is bound; settle time shortened to 64 cycles. */
`timescale 1ns/1ps
module testbench;
  import otc_pkg::*;
  logic mclk, srst, wr_stb, rd_stb, main_osc_tick, rc_osc_tick, main_on;
  logic [3:0] addr, cfg;
  logic [7:0] wr_data, d, v;
  logic [3:0] primary_clock_config;
  logic [2:0] internal_freq_select;
  logic [4:0] osc_trim_code;
  logic main_osc_enable, freq_multiplier_active;
  logic low_freq_source_select, low_freq_tick;
  logic [15:0] base_freq_khz, device_freq_khz;
  int errors = 0;
  int checked = 0;
  int n;

  otc_osc_ctrl #(.SETTLE_CYCLES(64)) i_dut (.mclk, .srst, .addr, .wr_data,
    .wr_stb, .rd_stb, .rd_data(v), .primary_clock_config,
    .internal_freq_select, .main_osc_tick, .rc_osc_tick, .osc_trim_code,
    .main_osc_enable, .freq_multiplier_active, .low_freq_source_select,
    .low_freq_tick, .base_freq_khz, .device_freq_khz);

  // 40 MHz clock; oscillator ticks random unless forced
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    rc_osc_tick <= 1'($urandom);
    main_osc_tick <= main_on | 1'($urandom);
  end

  task automatic check(string name, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : check

  task automatic wr(logic [3:0] a, logic [7:0] dd);
    @(posedge mclk);
    addr <= a;
    wr_data <= dd;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [7:0] e, string name);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    check(name, {8'h00, e}, {8'h00, v});
  endtask : rd

  function automatic logic [7:0] exp_reg(logic [7:0] x, logic [3:0] c,
    logic [2:0] s);
    return {x[7], x[6] & (c inside {4'h9, 4'h8}) & (s inside {3'h7, 3'h6}),
      1'b0, x[4:0]};
  endfunction : exp_reg

  // Bounded wait for the slewed trim to reach its target
  task automatic wait_trim(logic [4:0] t);
    n = 0;
    // Look between edges so the code launched at an edge is settled
    while (osc_trim_code !== t && n < 66) begin
      @(negedge mclk);
      n++;
    end
    check("osc_trim_code", 16'(t), 16'(osc_trim_code));
    if (osc_trim_code !== t) begin
      report_and_stop();
    end
  endtask : wait_trim

  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    {addr, wr_data, wr_stb, rd_stb, main_on} = '0;
    {main_osc_tick, rc_osc_tick} = '0;
    primary_clock_config = 4'h9;
    internal_freq_select = 3'h7;
    n = $urandom(32'h2266f988);
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(4'h0, 8'h00, "reset value");
    // Every select code, qualified and random configs, unmapped places
    for (int i = 0; i < 24; i++) begin
      cfg = (i % 3 == 2) ? 4'($urandom) : ((i % 3 == 1) ? 4'h8 : 4'h9);
      primary_clock_config <= cfg;
      internal_freq_select <= 3'(i);
      d = 8'($urandom);
      wr(4'h0, d);
      wr(4'(i % 15 + 1), ~d);
      rd(4'h0, exp_reg(d, cfg, 3'(i)), "trim register");
      rd(4'(i % 15 + 1), 8'h00, "unmapped");
    end
    // Multiplier at 8 and 4 MHz, then lost qualification
    primary_clock_config <= 4'h9;
    internal_freq_select <= 3'h7;
    wr(4'h0, 8'h40);
    repeat (4) @(posedge mclk);
    check("base 8M", 16'h1f40, base_freq_khz);
    check("device 32M", 16'h7d00, device_freq_khz);
    internal_freq_select <= 3'h6;
    repeat (4) @(posedge mclk);
    check("device 16M", 16'h3e80, device_freq_khz);
    internal_freq_select <= 3'h5;
    repeat (4) @(posedge mclk);
    rd(4'h0, 8'h00, "enable lost");
    check("device 2M", 16'h07d0, device_freq_khz);
    // Extreme trims settle within the shortened settle time
    wr(4'h0, 8'h10);
    wait_trim(5'h10);
    wr(4'h0, 8'h0f);
    wait_trim(5'h0f);
    wr(4'h0, 8'h00);
    wait_trim(5'h00);
    // Divided low-frequency clock at 31 kHz select
    internal_freq_select <= 3'h0;
    main_on <= 1'b1;
    wr(4'h0, 8'h80);
    repeat (4) @(posedge mclk);
    n = 0;
    repeat (1024) begin
      @(posedge mclk);
      n += int'(low_freq_tick === 1'b1);
    end
    check("divided ticks", 16'h0004, 16'(n));
    check("main osc on", 16'h0001, 16'(main_osc_enable));
    wr(4'h0, 8'h00);
    repeat (3) @(posedge mclk);
    check("main osc off", 16'h0000, 16'(main_osc_enable));
    check("base 31k", 16'h001f, base_freq_khz);
    // Reset in mid-run restores register
    wr(4'h0, 8'h9f);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(4'h0, 8'h00, "second reset");
    report_and_stop();
  end
endmodule : testbench
